//--- design/sat_ctrl.sv
`timescale 1ns/10ps
module sat_ctrl (
    // core clock and reset
    input  wire logic                       CLOCK,
    input  wire logic                       RSTN,
    // serial control link
    input  wire logic                       SCLK,
    input  wire logic                       SDIN,
    input  wire logic                       SHIFT_N,
    output logic                            SDOUT,
    // channel one tap switches
    output logic [sat_pkg::TAP_N-1:0]       CH0_TAP,
    output logic                            CH0_LINK,
    output logic [7:0]                      CH0_ATTEN,
    // channel two tap switches
    output logic [sat_pkg::TAP_N-1:0]       CH1_TAP,
    output logic                            CH1_LINK,
    output logic [7:0]                      CH1_ATTEN
);

    typedef struct packed {
        logic                                          ld_s1;
        logic                                          ld_s2;
        logic                                          ld_s3;
        sat_pkg::sat_state_t                           st;
        logic [sat_pkg::FRAME_W-1:0]                   cmd;
        logic [sat_pkg::CH_N-1:0][7:0]                 code;
        logic [sat_pkg::CH_N-1:0][sat_pkg::TAP_N-1:0]  tap;
        logic [sat_pkg::CH_N-1:0]                      link;
        logic [sat_pkg::CH_N-1:0][7:0]                 atten;
    } sat_ctrl_st_t;

    localparam sat_ctrl_st_t ST_RESET = '{
        ld_s1: sat_pkg::STROBE_IDLE,
        ld_s2: sat_pkg::STROBE_IDLE,
        ld_s3: sat_pkg::STROBE_IDLE,
        st:    sat_pkg::ST_IDLE,
        cmd:   '0,
        code:  {sat_pkg::CH_N{sat_pkg::CODE_RESET}},
        tap:   '0,
        link:  '0,
        atten: {sat_pkg::CH_N{sat_pkg::ATTEN_MUTE}}
    };

    sat_ctrl_st_t st_q;
    sat_ctrl_st_t st_d;

    logic                        strobe_rise;
    logic [7:0]                  cmd_addr;
    logic [7:0]                  cmd_code;
    logic [sat_pkg::TAP_N-1:0]   dec_tap;
    logic                        dec_link;
    logic [7:0]                  dec_atten;

    sat_frame_if frm_if ();

    // address byte selects channel c
    function automatic logic chan_hit(input logic [7:0] addr, input int c);
        chan_hit = (addr == sat_pkg::CH_ADDR[c]);
    endfunction

    // the mute test is used by several checks, keep one copy of it
    function automatic logic is_mute(input logic [7:0] code);
        is_mute = (code >= sat_pkg::CODE_MUTE);
    endfunction

    // serial side: shifting and daisy-chain output on the link clock
    sat_shift u_shift (
        .sclk    (SCLK),
        .rstn    (RSTN),
        .sdin    (SDIN),
        .shift_n (SHIFT_N),
        .sdout   (SDOUT),
        .frm     (frm_if.src)
    );

    // one decoder serves both channels, only one is written per command
    sat_decode u_decode (
        .code  (cmd_code),
        .tap   (dec_tap),
        .link  (dec_link),
        .atten (dec_atten)
    );

    assign cmd_addr    = st_q.cmd[sat_pkg::ADDR_HI:sat_pkg::ADDR_LO];
    assign cmd_code    = st_q.cmd[sat_pkg::CODE_HI:sat_pkg::CODE_LO];
    // edge seen on the second and third flops, never the first
    assign strobe_rise = st_q.ld_s2 & ~st_q.ld_s3;

    // limitation: the frame word crosses without a handshake; it is safe
    // only because the serial side shifts only while the strobe is low,
    // so the word sits still for the whole capture window
    // sequencer: the frame is read only after the strobe is seen high,
    // when the serial side has stopped shifting and the word is still
    always_comb begin
        st_d       = st_q;
        st_d.ld_s1 = SHIFT_N;
        st_d.ld_s2 = st_q.ld_s1;
        st_d.ld_s3 = st_q.ld_s2;
        case (st_q.st)
            sat_pkg::ST_IDLE: begin
                if (strobe_rise) begin
                    st_d.cmd = frm_if.frame;
                    st_d.st  = sat_pkg::ST_APPLY;
                end
            end
            sat_pkg::ST_APPLY: begin
                for (int c = 0; c < sat_pkg::CH_N; c++) begin
                    // unmatched address touches no channel
                    if (chan_hit(cmd_addr, c)) begin
                        st_d.code[c]  = cmd_code;
                        st_d.tap[c]   = dec_tap;
                        st_d.link[c]  = dec_link;
                        st_d.atten[c] = dec_atten;
                    end
                end
                st_d.st = sat_pkg::ST_IDLE;
            end
            default: begin
                st_d.st = sat_pkg::ST_IDLE;
            end
        endcase
        if (!RSTN) begin
            st_d = ST_RESET;
        end
    end

    always_ff @(posedge CLOCK) begin
        st_q <= st_d;
    end

    // tap drives straight from flops so switches never glitch
    assign CH0_TAP   = st_q.tap[0];
    assign CH0_LINK  = st_q.link[0];
    assign CH0_ATTEN = st_q.atten[0];
    assign CH1_TAP   = st_q.tap[1];
    assign CH1_LINK  = st_q.link[1];
    assign CH1_ATTEN = st_q.atten[1];

    default clocking dc @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);

    // command capture and sequencing
    latch_cmd_a: assert property (
        strobe_rise && st_q.st == sat_pkg::ST_IDLE |=> st_q.cmd == $past(frm_if.frame))
        else $error("command not captured on strobe rise");

    chain_latch_a: assert property (
        $rose(st_q.ld_s2) |=> st_q.st == sat_pkg::ST_APPLY ##1 st_q.st == sat_pkg::ST_IDLE)
        else $error("strobe rise not followed by apply then idle");

    hold_set_a: assert property (
        st_q.st != sat_pkg::ST_APPLY |=> $stable(st_q.code) && $stable(st_q.tap))
        else $error("channel setting changed without a command");

    bad_addr_a: assert property (
        st_q.st == sat_pkg::ST_APPLY && !chan_hit(cmd_addr, 0) && !chan_hit(cmd_addr, 1)
        |=> $stable(st_q.code) && $stable(st_q.link))
        else $error("unknown address changed a channel");

    reset_mute_a: assert property (@(posedge CLOCK) disable iff (1'b0)
        !RSTN |=> st_q.code == {sat_pkg::CH_N{sat_pkg::CODE_RESET}} && st_q.link == '0)
        else $error("channels not muted after reset");

    // per-channel checks
    for (genvar c = 0; c < sat_pkg::CH_N; c++) begin : g_chk
        update_ch_a: assert property (
            st_q.st == sat_pkg::ST_APPLY && chan_hit(cmd_addr, c)
            |=> st_q.code[c] == $past(cmd_code) && st_q.atten[c] == $past(dec_atten))
            else $error("addressed channel not updated");

        one_tap_a: assert property (
            st_q.link[c] |-> $onehot(st_q.tap[c]) && st_q.tap[c][st_q.code[c][6:0]])
            else $error("not exactly the coded tap enabled");

        indep_ch_a: assert property (
            st_q.st == sat_pkg::ST_APPLY && !chan_hit(cmd_addr, c)
            |=> $stable(st_q.code[c]) && $stable(st_q.atten[c]))
            else $error("other channel disturbed by command");

        mute_open_a: assert property (
            st_q.code[c] >= sat_pkg::CODE_MUTE |-> !st_q.link[c] && st_q.tap[c] == '0)
            else $error("muted channel still connected");

        mute_code_a: assert property (
            (st_q.code[c] == 8'h7e |-> st_q.atten[c] == 8'h9c)
            and (st_q.code[c] == 8'h7c |-> st_q.atten[c] == 8'h98)
            and (st_q.code[c] >= 8'h7f |-> st_q.atten[c] == sat_pkg::ATTEN_MUTE))
            else $error("top codes decoded to wrong level");

        fine_step_a: assert property (
            (st_q.code[c] < 8'h60 |-> st_q.atten[c] == st_q.code[c])
            and (st_q.code[c] == 8'h60 |-> st_q.atten[c] == 8'h60)
            and (st_q.code[c] == 8'h61 |-> st_q.atten[c] == 8'h62))
            else $error("step size wrong for code");

        // mute and link report must agree, the switch has no half state
        link_atten_a: assert property (
            st_q.link[c] == (st_q.atten[c] != sat_pkg::ATTEN_MUTE))
            else $error("link and attenuation report disagree");

        // an open channel must drive no tap at all
        open_no_tap_a: assert property (
            !st_q.link[c] |-> st_q.tap[c] == '0)
            else $error("muted channel has a tap switch closed");

        // outside apply nothing of this channel may move
        keep_ch_a: assert property (
            st_q.st != sat_pkg::ST_APPLY |=> $stable(st_q.link[c]) && $stable(st_q.atten[c]))
            else $error("channel report changed without a command");

        // a mute code sent to this channel must open it at once
        mute_apply_a: assert property (
            st_q.st == sat_pkg::ST_APPLY && chan_hit(cmd_addr, c) && is_mute(cmd_code)
            |=> !st_q.link[c] && st_q.tap[c] == '0)
            else $error("mute code did not open the channel");

        // an audible code must close its own tap and raise the link
        tap_apply_a: assert property (
            st_q.st == sat_pkg::ST_APPLY && chan_hit(cmd_addr, c) && !is_mute(cmd_code)
            |=> st_q.link[c] && st_q.tap[c][$past(cmd_code[6:0])])
            else $error("audible code did not close its own tap");

        // stored code and link state must tell the same story
        code_link_a: assert property (
            st_q.link[c] == !is_mute(st_q.code[c]))
            else $error("link state does not match stored code");

        // an audible setting never reports more than 78 dB
        atten_range_a: assert property (
            st_q.link[c] |-> st_q.atten[c] <= 8'h9c)
            else $error("audible setting beyond top step");

        // last half step and a middle top step land where expected
        top_codes_a: assert property (
            (st_q.code[c] == 8'h5f |-> st_q.atten[c] == 8'h5f)
            and (st_q.code[c] == 8'h7d |-> st_q.atten[c] == 8'h9a))
            else $error("boundary code decoded to wrong level");
    end

    // sequencer bookkeeping
    // an illegal state code is sent back to idle by the default branch
    state_code_a: assert property (
        st_q.st == sat_pkg::ST_IDLE || st_q.st == sat_pkg::ST_APPLY)
        else $error("sequencer left its legal states");

    // apply is a single cycle, then back to waiting
    apply_once_a: assert property (
        st_q.st == sat_pkg::ST_APPLY |=> st_q.st == sat_pkg::ST_IDLE)
        else $error("apply state held for more than one cycle");

    // the command word moves only at a seen strobe rise
    cmd_hold_a: assert property (
        !(strobe_rise && st_q.st == sat_pkg::ST_IDLE) |=> $stable(st_q.cmd))
        else $error("command word changed without a strobe rise");

    // reset also opens every tap and reports mute
    reset_taps_a: assert property (@(posedge CLOCK) disable iff (1'b0)
        !RSTN |=> st_q.tap == '0 && st_q.atten == {sat_pkg::CH_N{sat_pkg::ATTEN_MUTE}})
        else $error("taps or report not cleared by reset");

    // main scenarios
    ch0_set_c:  cover property (st_q.st == sat_pkg::ST_APPLY && chan_hit(cmd_addr, 0)
                                ##1 st_q.link[0]);
    ch1_set_c:  cover property (st_q.st == sat_pkg::ST_APPLY && chan_hit(cmd_addr, 1)
                                ##1 st_q.link[1]);
    remute_c:   cover property ($fell(st_q.link[0]));
    bad_addr_c: cover property (st_q.st == sat_pkg::ST_APPLY && cmd_addr > 8'h01);
    mute_c:     cover property (st_q.st == sat_pkg::ST_APPLY
                                && is_mute(cmd_code));

endmodule

//--- design/sat_decode.sv
`timescale 1ns/10ps
module sat_decode (
    // attenuation code in
    input  wire logic [7:0]                code,
    // tap selection out
    output logic [sat_pkg::TAP_N-1:0]      tap,
    output logic                           link,
    output logic [7:0]                     atten
);

    // one tap per audible code, none at all when muted
    always_comb begin
        tap  = '0;
        link = (code < sat_pkg::CODE_MUTE);
        if (link) begin
            tap[code[6:0]] = 1'b1;
        end
        if (!link) begin
            atten = sat_pkg::ATTEN_MUTE;
        end else if (code < sat_pkg::CODE_COARSE) begin
            atten = code;
        end else begin
            // 1 dB steps: twice the code, rebased to 48 dB
            atten = {code[6:0], 1'b0} - sat_pkg::ATTEN_COARSE_BASE;
        end
    end

endmodule

//--- design/sat_frame_if.sv
`timescale 1ns/10ps
// shift register contents passed from the serial clock side to the core
interface sat_frame_if;
    logic [sat_pkg::FRAME_W-1:0] frame;

    modport src (output frame);
    modport dst (input  frame);
endinterface

//--- design/sat_pkg.sv
package sat_pkg;

    // frame layout: address byte first, then attenuation code, msb first
    localparam int FRAME_W = 16;
    localparam int BYTE_W  = 8;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 8;
    localparam int CODE_HI = 7;
    localparam int CODE_LO = 0;

    // channels and their address bytes
    localparam int                      CH_N    = 2;
    localparam logic [CH_N-1:0][7:0]    CH_ADDR = {8'h01, 8'h00};

    // attenuation code map
    localparam int         TAP_N       = 127;       // codes 0x00..0x7e each own a tap
    localparam logic [7:0] CODE_MUTE   = 8'h7f;     // first muting code
    localparam logic [7:0] CODE_COARSE = 8'h60;     // first 1 dB step code
    localparam logic [7:0] CODE_RESET  = 8'h7f;     // power-up code, muted

    // attenuation report in half-dB units
    localparam logic [7:0] ATTEN_COARSE_BASE = 8'h60;   // 2*0x60 - 0x60 = 48 dB
    localparam logic [7:0] ATTEN_MUTE        = 8'hc8;   // 100 dB, mute

    // latch strobe idle level, used as synchroniser reset value
    localparam logic STROBE_IDLE = 1'b1;

    // command sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_APPLY = 2'b10
    } sat_state_t;

endpackage

//--- design/sat_shift.sv
`timescale 1ns/10ps
module sat_shift (
    // serial link, clocked by the controller
    input  wire logic sclk,
    input  wire logic rstn,
    input  wire logic sdin,
    input  wire logic shift_n,
    output logic      sdout,
    // frame towards the core
    sat_frame_if.src  frm
);

    typedef struct packed {
        logic                        rst_s1;
        logic                        rst_s2;
        logic [sat_pkg::FRAME_W-1:0] shreg;
    } sat_shift_st_t;

    sat_shift_st_t st_q;
    sat_shift_st_t st_d;

    // reset is brought into the serial domain through two flops;
    // the serial clock may stop, so this only acts while it runs
    always_comb begin
        st_d        = st_q;
        st_d.rst_s1 = rstn;
        st_d.rst_s2 = st_q.rst_s1;
        if (!st_q.rst_s2) begin
            st_d.shreg = '0;
        end else if (!shift_n) begin
            st_d.shreg = {st_q.shreg[sat_pkg::FRAME_W-2:0], sdin};
        end
    end

    always_ff @(posedge sclk) begin
        st_q <= st_d;
    end

    // the msb leaves first, so the next device samples the old msb
    assign sdout     = st_q.shreg[sat_pkg::FRAME_W-1];
    assign frm.frame = st_q.shreg;

    shift_in_a: assert property (@(posedge sclk) disable iff (!st_q.rst_s2)
        !shift_n |=> st_q.shreg[0] == $past(sdin))
        else $error("serial input bit not shifted in");

    push_out_a: assert property (@(posedge sclk) disable iff (!st_q.rst_s2)
        !shift_n ##1 !shift_n |-> sdout == $past(st_q.shreg[sat_pkg::FRAME_W-2], 1))
        else $error("serial output does not carry the pushed bit");

    hold_high_a: assert property (@(posedge sclk) disable iff (!st_q.rst_s2)
        shift_n |=> $stable(st_q.shreg))
        else $error("shift register moved while strobe high");

endmodule

//--- tb/sat_host.sv
`timescale 1ns/10ps
// controller side of the three-wire link; its clock runs inside frames and in the reset wake bursts
module sat_host (
    // serial link towards the device
    output logic      SCLK,
    output logic      SDIN,
    output logic      SHIFT_N,
    // daisy-chain return
    input  wire logic SDOUT
);
    logic [31:0] seen;

    // idle link: strobe high, clock low
    initial begin
        SCLK    = 1'b0;
        SDIN    = 1'b0;
        SHIFT_N = 1'b1;
        seen    = 32'h0;
    end

    // strobe low, n bits msb first at 32 ns, strobe high
    task automatic send(input logic [31:0] bits, input int n);
        SHIFT_N = 1'b0;
        #150;
        for (int i = n - 1; i >= 0; i--) begin
            SDIN = bits[i];
            #16 seen = {seen[30:0], SDOUT};
            SCLK = 1'b1;
            #16 SCLK = 1'b0;
        end
        // a released data line must not keep its last level
        SDIN = ~SDIN;
        #150 SHIFT_N = 1'b1;
        #200;
    endtask

    // clock edges with strobe high, only so the reset reaches the link side
    task automatic wake();
        repeat (4) begin
            #16 SCLK = 1'b1;
            #16 SCLK = 1'b0;
        end
    endtask
endmodule

//--- tb/serial_attenuator_ctrl_bench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
    begin checks_done++; if ((gt) !== (ex)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module serial_attenuator_ctrl_bench;
    typedef struct {logic [7:0] a; logic [7:0] c; logic [7:0] e;} sat_row_t;
    logic                      clock;
    logic                      rstn;
    logic                      sclk;
    logic                      sdin;
    logic                      shift_n;
    logic                      sdout;
    logic [sat_pkg::TAP_N-1:0] tap0;
    logic [sat_pkg::TAP_N-1:0] tap1;
    logic                      link0;
    logic                      link1;
    logic [7:0]                att0;
    logic [7:0]                att1;
    logic [7:0]                e_code [2];
    int                        bad_count;
    int                        checks_done;
    // ordinary frames: address, code, expected attenuation in half-dB units
    sat_row_t rows [14] = '{'{8'h00, 8'h00, 8'h00}, '{8'h00, 8'h01, 8'h01},
        '{8'h00, 8'h5f, 8'h5f}, '{8'h00, 8'h60, 8'h60}, '{8'h00, 8'h61, 8'h62},
        '{8'h00, 8'h7c, 8'h98}, '{8'h00, 8'h7d, 8'h9a}, '{8'h00, 8'h7e, 8'h9c},
        '{8'h00, 8'h7f, 8'hc8}, '{8'h00, 8'h80, 8'hc8}, '{8'h00, 8'hff, 8'hc8},
        '{8'h01, 8'h30, 8'h30}, '{8'h01, 8'h7e, 8'h9c}, '{8'h01, 8'hfe, 8'hc8}};

    sat_ctrl u_sat_ctrl (.CLOCK(clock), .RSTN(rstn), .SCLK(sclk), .SDIN(sdin),
        .SHIFT_N(shift_n), .SDOUT(sdout), .CH0_TAP(tap0), .CH0_LINK(link0),
        .CH0_ATTEN(att0), .CH1_TAP(tap1), .CH1_LINK(link1), .CH1_ATTEN(att1));

    sat_host u_sat_host (.SCLK(sclk), .SDIN(sdin), .SHIFT_N(shift_n), .SDOUT(sdout));

    // 40 MHz core clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // half-dB units: half steps up to 5f, then 1 dB from 48 dB, mute above 7e
    function automatic logic [7:0] exp_att(input logic [7:0] c);
        if (c >= 8'h7f) return 8'hc8;
        if (c >= 8'h60) return {c[6:0], 1'b0} - 8'h60;
        return c;
    endfunction

    function automatic logic [sat_pkg::TAP_N-1:0] exp_tap(input logic [7:0] c);
        exp_tap = '0;
        if (c < 8'h7f) exp_tap[c[6:0]] = 1'b1;
    endfunction

    // both channels against their expected codes, off the clock edge
    task automatic check_all(input string nm);
        @(posedge clock) #2;
        for (int ch = 0; ch < 2; ch++) begin
            `CHK({nm, " atten"}, exp_att(e_code[ch]), ch ? att1 : att0)
            `CHK({nm, " link"}, e_code[ch] < 8'h7f, ch ? link1 : link0)
            `CHK({nm, " tap"}, exp_tap(e_code[ch]), ch ? tap1 : tap0)
        end
    endtask

    // reset must also see link clock edges, both during and after it
    task automatic do_reset();
        @(posedge clock) #2 rstn = 1'b0;
        u_sat_host.wake();
        repeat (16) @(posedge clock);
        #2 rstn = 1'b1;
        u_sat_host.wake();
        e_code = '{8'h7f, 8'h7f};
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        bad_count = 0;
        checks_done = 0;
        do_reset();
        check_all("power-up");
        $display("test power-up done");
        foreach (rows[i]) begin
            u_sat_host.send({16'h0, rows[i].a, rows[i].c}, 16);
            e_code[rows[i].a[0]] = rows[i].c;
            check_all("row");
            `CHK("row atten", rows[i].e, rows[i].a[0] ? att1 : att0)
        end
        $display("test table done");
        // an address of no channel changes nothing
        u_sat_host.send({16'h0, 16'h0210}, 16);
        check_all("bad address");
        $display("test bad address done");
        // two frames in one strobe: last one latched, older bits pushed out
        u_sat_host.send({16'h0131, 16'h005a}, 32);
        e_code[0] = 8'h5a;
        `CHK("chain out", 32'h02100131, u_sat_host.seen)
        check_all("chain");
        $display("test chain done");
        do_reset();
        check_all("second reset");
        $display("test second reset done");
        // shift register cleared by reset: first frame pushes out zeros
        u_sat_host.send({16'h0, 16'h0001}, 16);
        e_code[0] = 8'h01;
        `CHK("reset out", 16'h0000, u_sat_host.seen[15:0])
        check_all("after reset");
        $display("test reset out done");
        report_and_stop();
    end

    // watchdog, well beyond the roughly 20 us the tests take
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
endmodule
